// ==== general_timers.sv ====
`timescale 1ns/10ps
`default_nettype none
module general_timers
  import timers_pkg::*;
(
  input  wire logic        clock,            // 25 MHz system clock
  input  wire logic        rst_n,            // sync reset, active low
  input  wire logic [9:0]  avs_address,      // byte address
  input  wire logic        avs_read,         // read strobe
  input  wire logic        avs_write,        // write strobe
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte lanes
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall
  input  wire logic        timer0_count_pin, // timer 0 count input
  input  wire logic        timer1_count_pin, // timer 1 count input
  input  wire logic        external_gate_input_a, // timer 0 gate
  input  wire logic        external_gate_input_b, // timer 1 gate
  input  wire logic        ext_clock_in,     // external clock source
  output logic             irq               // level interrupt
);
  import timers_pkg::*;
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] tctrl_reg, tmode_reg, ckctl_reg, extcfg_reg, t2ctl_reg;
  logic [7:0] t0lo_reg, t0hi_reg, t1lo_reg, t1hi_reg;
  logic [7:0] t2lo_reg, t2hi_reg, t2rll_reg, t2rlh_reg;
  logic [NUM_IRQ-1:0] istat_reg, imask_reg;
  logic       ack_reg;
  // ************************************************************
  // bus decode
  // ************************************************************
  wire        word_ok = (avs_address[1:0] == 2'b00);
  wire [7:0]  idx     = avs_address[9:2];
  // commit on the answer edge, the one where the master sees waitrequest low
  wire        wr      = avs_write && ack_reg && word_ok && avs_byteenable[0];
  wire [7:0]  wd      = avs_writedata[7:0];
  wire w_tctrl  = wr && idx == IDX_TCTRL;
  wire w_tmode  = wr && idx == IDX_TMODE;
  wire w_t0lo   = wr && idx == IDX_T0LO;
  wire w_t1lo   = wr && idx == IDX_T1LO;
  wire w_t0hi   = wr && idx == IDX_T0HI;
  wire w_t1hi   = wr && idx == IDX_T1HI;
  wire w_ckctl  = wr && idx == IDX_CKCTL;
  wire w_extcfg = wr && idx == IDX_EXTCFG;
  wire w_t2ctl  = wr && idx == IDX_T2CTL;
  wire w_t2rll  = wr && idx == IDX_T2RLL;
  wire w_t2rlh  = wr && idx == IDX_T2RLH;
  wire w_t2lo   = wr && idx == IDX_T2LO;
  wire w_t2hi   = wr && idx == IDX_T2HI;
  wire w_istat  = wr && idx == IDX_ISTAT;
  wire w_imask  = wr && idx == IDX_IMASK;
  // ************************************************************
  // clock sources
  // ************************************************************
  logic tick4, tick12, tick48, ext_fall, ext_tick8;
  logic ext_lvl;
  pulse_divider #(.DIV(DIV_SYS4)) u_div4 (
    .clock(clock), .rst_n(rst_n), .tick_in(1'b1), .tick_out(tick4));
  pulse_divider #(.DIV(DIV_SYS12)) u_div12 (
    .clock(clock), .rst_n(rst_n), .tick_in(1'b1), .tick_out(tick12));
  pulse_divider #(.DIV(DIV_SYS48)) u_div48 (
    .clock(clock), .rst_n(rst_n), .tick_in(1'b1), .tick_out(tick48));
  edge_sync u_ext (
    .clock(clock), .rst_n(rst_n), .pin(ext_clock_in),
    .level(ext_lvl), .fall(ext_fall));
  pulse_divider #(.DIV(DIV_EXT8)) u_div8 (
    .clock(clock), .rst_n(rst_n), .tick_in(ext_fall), .tick_out(ext_tick8));
  // shared scale field: 0 /12, 1 /4, 2 /48, 3 ext/8
  logic scaled_tick;
  always_comb begin
    case (ckctl_reg[1:0])
      2'd0:    scaled_tick = tick12;
      2'd1:    scaled_tick = tick4;
      2'd2:    scaled_tick = tick48;
      default: scaled_tick = ext_tick8;
    endcase
  end
  // ************************************************************
  // timers 0 and 1 inputs
  // ************************************************************
  logic c0_lvl, c1_lvl, c0_fall, c1_fall, ga_lvl, gb_lvl;
  edge_sync u_c0 (.clock(clock), .rst_n(rst_n), .pin(timer0_count_pin),
    .level(c0_lvl), .fall(c0_fall));
  edge_sync u_c1 (.clock(clock), .rst_n(rst_n), .pin(timer1_count_pin),
    .level(c1_lvl), .fall(c1_fall));
  edge_sync u_ga (.clock(clock), .rst_n(rst_n),
    .pin(external_gate_input_a), .level(ga_lvl), .fall());
  edge_sync u_gb (.clock(clock), .rst_n(rst_n),
    .pin(external_gate_input_b), .level(gb_lvl), .fall());
  wire ga_act = ga_lvl == extcfg_reg[EX_A_POL];
  wire gb_act = gb_lvl == extcfg_reg[EX_B_POL];
  wire run0 = tctrl_reg[TC_TR0] && (!tmode_reg[TM_TIMER0_GATE_BIT] || ga_act);
  wire run1 = tctrl_reg[TC_TR1] && (!tmode_reg[TM_GATE1] || gb_act);
  wire src0 = tmode_reg[TM_CT0] ? c0_fall :
              (ckctl_reg[CK_T0M] ? 1'b1 : scaled_tick);
  wire src1 = tmode_reg[TM_CT1] ? c1_fall :
              (ckctl_reg[CK_T1M] ? 1'b1 : scaled_tick);
  wire inc0 = run0 && src0;
  wire inc1 = run1 && src1;
  // only mode 0 (13-bit) is counted; mode bits [1:0]/[5:4] stored
  wire [12:0] cnt0 = {t0hi_reg, t0lo_reg[4:0]};
  wire [12:0] cnt1 = {t1hi_reg, t1lo_reg[4:0]};
  wire [12:0] nxt0 = cnt0 + 13'h0001;
  wire [12:0] nxt1 = cnt1 + 13'h0001;
  wire ovf0 = inc0 && (cnt0 == 13'h1FFF);
  wire ovf1 = inc1 && (cnt1 == 13'h1FFF);
  // ************************************************************
  // timer 2 split halves
  // ************************************************************
  wire split = t2ctl_reg[T2_SPL];
  wire base2 = t2ctl_reg[T2_XCLK] ? ext_tick8 : tick12;
  wire src2l = ckctl_reg[CK_TIMER2_LOW_CLOCK_SELECT] ? 1'b1 : base2;
  wire src2h = ckctl_reg[CK_TIMER2_HIGH_CLOCK_SELECT] ? 1'b1 : base2;
  wire inc2l = split && src2l;
  wire inc2h = split && t2ctl_reg[T2_TR] && src2h;
  wire ovf2l = inc2l && (t2lo_reg == 8'hFF);
  wire ovf2h = inc2h && (t2hi_reg == 8'hFF);
  wire irq2 = ovf2h || (ovf2l && t2ctl_reg[T2_LEN]);
  // ************************************************************
  // control and count registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmode_reg  <= RESET_BYTE;
      ckctl_reg  <= RESET_BYTE;
      extcfg_reg <= RESET_BYTE;
      t2rll_reg  <= RESET_BYTE;
      t2rlh_reg  <= RESET_BYTE;
    end else begin
      if (w_tmode)  tmode_reg  <= wd;
      if (w_ckctl)  ckctl_reg  <= wd;
      if (w_extcfg) extcfg_reg <= wd;
      if (w_t2rll)  t2rll_reg  <= wd;
      if (w_t2rlh)  t2rlh_reg  <= wd;
    end
  end
  // flags: hardware set wins over a software write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tctrl_reg <= RESET_BYTE;
    end else begin
      if (w_tctrl) tctrl_reg <= wd;
      if (ovf0) tctrl_reg[TC_TF0] <= 1'b1;
      if (ovf1) tctrl_reg[TC_TF1] <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      t2ctl_reg <= RESET_BYTE;
    end else begin
      if (w_t2ctl) t2ctl_reg <= wd;
      if (ovf2h) t2ctl_reg[T2_TFH] <= 1'b1;
      if (ovf2l) t2ctl_reg[T2_TFL] <= 1'b1;
    end
  end
  // count write has priority over increment
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      t0lo_reg <= RESET_BYTE;
      t0hi_reg <= RESET_BYTE;
      t1lo_reg <= RESET_BYTE;
      t1hi_reg <= RESET_BYTE;
    end else begin
      if (w_t0lo) t0lo_reg <= wd;
      else if (inc0) t0lo_reg <= {t0lo_reg[7:5], nxt0[4:0]};
      if (w_t0hi) t0hi_reg <= wd;
      else if (inc0) t0hi_reg <= nxt0[12:5];
      if (w_t1lo) t1lo_reg <= wd;
      else if (inc1) t1lo_reg <= {t1lo_reg[7:5], nxt1[4:0]};
      if (w_t1hi) t1hi_reg <= wd;
      else if (inc1) t1hi_reg <= nxt1[12:5];
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      t2lo_reg <= RESET_BYTE;
      t2hi_reg <= RESET_BYTE;
    end else begin
      if (w_t2lo) t2lo_reg <= wd;
      else if (ovf2l) t2lo_reg <= t2rll_reg;
      else if (inc2l) t2lo_reg <= t2lo_reg + 8'h01;
      if (w_t2hi) t2hi_reg <= wd;
      else if (ovf2h) t2hi_reg <= t2rlh_reg;
      else if (inc2h) t2hi_reg <= t2hi_reg + 8'h01;
    end
  end
  // ************************************************************
  // interrupts
  // ************************************************************
  wire [NUM_IRQ-1:0] ev = {irq2, ovf1, ovf0};
  wire [NUM_IRQ-1:0] clr = w_istat ? wd[NUM_IRQ-1:0] : '0;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      istat_reg <= '0;
      imask_reg <= '0;
      irq       <= 1'b0;
    end else begin
      istat_reg <= (istat_reg & ~clr) | ev;
      if (w_imask) imask_reg <= wd[NUM_IRQ-1:0];
      irq <= |(((istat_reg & ~clr) | ev) &
               (w_imask ? wd[NUM_IRQ-1:0] : imask_reg));
    end
  end
  // ************************************************************
  // read path: one wait cycle, answer on the second edge
  // ************************************************************
  logic [7:0] rmux;
  logic       hit;
  always_comb begin
    hit = 1'b1;
    case (idx)
      IDX_TCTRL:  rmux = tctrl_reg;
      IDX_TMODE:  rmux = tmode_reg;
      IDX_T0LO:   rmux = t0lo_reg;
      IDX_T1LO:   rmux = t1lo_reg;
      IDX_T0HI:   rmux = t0hi_reg;
      IDX_T1HI:   rmux = t1hi_reg;
      IDX_CKCTL:  rmux = ckctl_reg;
      IDX_EXTCFG: rmux = extcfg_reg;
      IDX_T2CTL:  rmux = t2ctl_reg;
      IDX_T2RLL:  rmux = t2rll_reg;
      IDX_T2RLH:  rmux = t2rlh_reg;
      IDX_T2LO:   rmux = t2lo_reg;
      IDX_T2HI:   rmux = t2hi_reg;
      IDX_ISTAT:  rmux = {5'h00, istat_reg};
      IDX_IMASK:  rmux = {5'h00, imask_reg};
      default: begin
        rmux = 8'h00;
        hit  = 1'b0;
      end
    endcase
  end
  wire req = (avs_read || avs_write) && !ack_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= UNMAPPED_READ;
    end else begin
      ack_reg         <= req;
      avs_waitrequest <= !req;
      if (avs_read && !ack_reg) begin
        avs_readdata <= (hit && word_ok) ? {24'h000000, rmux} : UNMAPPED_READ;
      end
    end
  end
endmodule
`default_nettype wire

// ==== timers_pkg.sv ====
package timers_pkg;
  // ************************************************************
  // register offsets (byte address = 4 * index)
  // ************************************************************
  localparam logic [7:0] IDX_TCTRL   = 8'h88;
  localparam logic [7:0] IDX_TMODE   = 8'h89;
  localparam logic [7:0] IDX_T0LO    = 8'h8A;
  localparam logic [7:0] IDX_T1LO    = 8'h8B;
  localparam logic [7:0] IDX_T0HI    = 8'h8C;
  localparam logic [7:0] IDX_T1HI    = 8'h8D;
  localparam logic [7:0] IDX_CKCTL   = 8'h8E;
  localparam logic [7:0] IDX_EXTCFG  = 8'hE4;
  localparam logic [7:0] IDX_T2CTL   = 8'hC8;
  localparam logic [7:0] IDX_T2RLL   = 8'hCA;
  localparam logic [7:0] IDX_T2RLH   = 8'hCB;
  localparam logic [7:0] IDX_T2LO    = 8'hCC;
  localparam logic [7:0] IDX_T2HI    = 8'hCD;
  localparam logic [7:0] IDX_ISTAT   = 8'hF0;
  localparam logic [7:0] IDX_IMASK   = 8'hF1;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  localparam int TM_GATE1 = 7;
  localparam int TM_CT1   = 6;
  localparam int TM_TIMER0_GATE_BIT = 3;
  localparam int TM_CT0   = 2;
  localparam int CK_TIMER2_HIGH_CLOCK_SELECT = 5;
  localparam int CK_TIMER2_LOW_CLOCK_SELECT = 4;
  localparam int CK_T1M  = 3;
  localparam int CK_T0M  = 2;
  localparam int EX_B_POL = 7;
  localparam int EX_A_POL = 3;
  localparam int T2_TFH  = 7;
  localparam int T2_TFL  = 6;
  localparam int T2_LEN  = 5;
  localparam int T2_SPL  = 3;
  localparam int T2_TR   = 2;
  localparam int T2_XCLK = 0;
  // status bits: 0 timer0, 1 timer1, 2 timer2
  localparam int NUM_IRQ = 3;
  // ************************************************************
  // reset values and divide counts
  // ************************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int DIV_SYS12 = 12;
  localparam int DIV_EXT8  = 8;
  localparam int DIV_SYS4  = 4;
  localparam int DIV_SYS48 = 48;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ==== pulse_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
module pulse_divider #(
  parameter int DIV = 12
) (
  input  wire logic clock,   // system clock
  input  wire logic rst_n,   // sync reset
  input  wire logic tick_in, // source enable
  output var  logic tick_out // one pulse per DIV ticks
);
  localparam int W = $clog2(DIV) + 1;
  logic [W-1:0] cnt_reg;
  wire          last = (cnt_reg == W'(DIV - 1));
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && last;
      if (tick_in) begin
        cnt_reg <= last ? '0 : cnt_reg + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== edge_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
  input  wire logic clock,   // system clock
  input  wire logic rst_n,   // sync reset
  input  wire logic pin,     // raw pin
  output var  logic level,   // synchronised level
  output logic      fall     // one-cycle falling edge pulse
);
  logic meta_reg;
  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      level    <= 1'b1;
    end else begin
      meta_reg <= pin;
      level    <= meta_reg;
    end
  end
  logic prev_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) prev_reg <= 1'b1;
    else prev_reg <= level;
  end
  assign fall = prev_reg && !level;
endmodule
`default_nettype wire

// ==== timers_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// bus and interrupt checks
// ********
module timers_asserts
  import timers_pkg::*;
(
  input wire logic        clock,           // system clock
  input wire logic        rst_n,           // sync reset
  input wire logic [9:0]  avs_address,     // byte address
  input wire logic        avs_read,        // read strobe
  input wire logic        avs_write,       // write strobe
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [3:0]  avs_byteenable,  // byte lanes
  input wire logic [31:0] avs_readdata,    // read data
  input wire logic        avs_waitrequest, // stall
  input wire logic        irq              // level interrupt
);
  wire logic req = avs_read || avs_write;
  wire logic mask_off = avs_write && avs_waitrequest && avs_byteenable[0]
    && avs_address == {IDX_IMASK, 2'b00} && avs_writedata[2:0] == 3'b000;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_after_take: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("no answer after request");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  a_idle_no_ack: assert property (!req |=> avs_waitrequest) else $error("answer without request");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h000000) else $error("upper read data set");
  a_rdata_holds: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address[9:2] == 8'h00 |=> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  a_mask_drops_irq: assert property (mask_off |=> ##1 !irq) else $error("irq kept after mask cleared");
  a_irq_sticky: assert property (irq && !avs_write && !$past(avs_write) |=> irq) else $error("irq dropped by itself");
endmodule
bind general_timers timers_asserts i_chk (.clock(clock), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq(irq));
`default_nettype wire

// ==== pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// count, gate and oscillator pins
// ********
module pin_model (
  input  wire logic clock,   // system clock
  output var  logic count0,  // timer 0 count pin
  output var  logic count1,  // timer 1 count pin
  output var  logic gate_a,  // timer 0 gate
  output var  logic gate_b,  // timer 1 gate
  output var  logic ext_clk  // oscillator, period 8 cycles
);
  logic [1:0] div;
  initial begin
    count0 = 1'b1;
    count1 = 1'b1;
    gate_a = 1'b0;
    gate_b = 1'b0;
    ext_clk = 1'b0;
    div = 2'd0;
  end
  // oscillator runs free, unlike the count pins
  always @(posedge clock) begin
    div <= div + 2'd1;
    if (div == 2'd3) ext_clk <= ~ext_clk;
  end
  // pulses long enough to pass the synchronisers
  task automatic pulse(input logic sel, input int n);
    repeat (n) begin
      @(posedge clock);
      if (sel) count1 <= 1'b0;
      else count0 <= 1'b0;
      repeat (4) @(posedge clock);
      count0 <= 1'b1;
      count1 <= 1'b1;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic gates(input logic a, input logic b);
    @(posedge clock);
    gate_a <= a;
    gate_b <= b;
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ==== general_timers_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module general_timers_test;
  import timers_pkg::*;
  logic        clock, rst_n, rd_en, wr_en, wait_req, irq;
  logic        c0, c1, ga, gb, xc;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [7:0]  got, v;
  int          fails, checked, seed, n;
  // oscillator period of the pin model, in system clocks
  localparam int EXT_PERIOD = 8;
  general_timers i_dut (.clock(clock), .rst_n(rst_n), .avs_address(addr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .timer0_count_pin(c0), .timer1_count_pin(c1),
    .external_gate_input_a(ga), .external_gate_input_b(gb),
    .ext_clock_in(xc), .irq(irq));
  pin_model i_pins (.clock(clock), .count0(c0), .count1(c1), .gate_a(ga),
    .gate_b(gb), .ext_clk(xc));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] lanes = 4'h1);
    @(posedge clock);
    addr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    be <= lanes;
    wr_en <= 1'b1;
    @(posedge clock iff wait_req === 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clock);
    addr <= {idx, 2'b00};
    rd_en <= 1'b1;
    @(posedge clock iff wait_req === 1'b0);
    got = rdata[7:0];
    rd_en <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [7:0] keep, input string what);
    rd(idx);
    chk(what, exp, got & keep);
  endtask
  // divider phase is free, so a window may hold one tick more
  function automatic logic [7:0] near_count(input logic [7:0] seen,
                                            input int ticks);
    return (seen == 8'(ticks) || seen == 8'(ticks + 1)) ? 8'h01 : 8'h00;
  endfunction
  // timer 1 on the shared scale field, run for twenty source periods
  task automatic scale_rate(input logic [1:0] sc, input int div);
    wr(IDX_TCTRL, 8'h00);
    wr(IDX_CKCTL, {6'h00, sc});
    wr(IDX_T1LO, 8'h00);
    wr(IDX_T1HI, 8'h00);
    wr(IDX_TCTRL, 8'h40);
    repeat (20 * div) @(posedge clock);
    wr(IDX_TCTRL, 8'h00);
    rd(IDX_T1LO);
    chk("t1 scaled rate", 8'h01, near_count(got, 20));
  endtask
  // split low half: flag clear early, set late
  task automatic t2_rate(input logic [7:0] ck, input logic [7:0] ctl,
                         input logic [7:0] load, input int early, late);
    wr(IDX_T2CTL, 8'h00);
    wr(IDX_CKCTL, ck);
    wr(IDX_T2LO, load);
    wr(IDX_T2CTL, ctl);
    repeat (early) @(posedge clock);
    rc(IDX_T2CTL, ctl, 8'hFF, "t2 rate early");
    repeat (late) @(posedge clock);
    rc(IDX_T2CTL, ctl | 8'h40, 8'hFF, "t2 rate late");
  endtask
  initial begin
    seed = 32'hBF43;
    fails = 0;
    checked = 0;
    rst_n = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 10'h000;
    wdata = 32'h00000000;
    be = 4'h1;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rc(IDX_T0LO, 8'h00, 8'hFF, "t0 low reset");
    rc(IDX_T1LO, 8'h00, 8'hFF, "t1 low reset");
    wr(8'h00, 8'hA5);
    rc(8'h00, 8'h00, 8'hFF, "unmapped");
    wr(IDX_T0LO, 8'h5A, 4'h0);
    rc(IDX_T0LO, 8'h00, 8'hFF, "lane off");
    v = 8'($random(seed)) & 8'h0F;
    n = 1 + ($random(seed) & 7);
    wr(IDX_EXTCFG, 8'h88);
    wr(IDX_TMODE, 8'h08);
    wr(IDX_T0LO, v);
    wr(IDX_TCTRL, 8'h10);
    repeat (20) @(posedge clock);
    rc(IDX_T0LO, v, 8'hFF, "t0 gated");
    wr(IDX_TMODE, 8'h0C);
    i_pins.gates(1'b1, 1'b0);
    i_pins.pulse(1'b0, n);
    repeat (6) @(posedge clock);
    rc(IDX_T0LO, v + 8'(n), 8'h1F, "t0 edges");
    i_pins.gates(1'b0, 1'b0);
    i_pins.pulse(1'b0, 3);
    rc(IDX_T0LO, v + 8'(n), 8'h1F, "t0 gate off");
    wr(IDX_EXTCFG, 8'h08);
    wr(IDX_TMODE, 8'hC0);
    wr(IDX_TCTRL, 8'h40);
    i_pins.pulse(1'b1, n);
    repeat (6) @(posedge clock);
    rc(IDX_T1LO, 8'(n), 8'h1F, "t1 edges");
    i_pins.gates(1'b0, 1'b1);
    i_pins.pulse(1'b1, 2);
    rc(IDX_T1LO, 8'(n), 8'h1F, "t1 gate off");
    wr(IDX_TMODE, 8'h00);
    wr(IDX_CKCTL, 8'h04);
    wr(IDX_T0HI, 8'hFF);
    wr(IDX_T0LO, 8'h1F);
    wr(IDX_IMASK, 8'h01);
    wr(IDX_TCTRL, 8'h10);
    repeat (4) @(posedge clock);
    rc(IDX_TCTRL, 8'h30, 8'hFF, "t0 flag");
    rc(IDX_T0HI, 8'h00, 8'hFF, "t0 wrap");
    rc(IDX_ISTAT, 8'h01, 8'hFF, "t0 status");
    chk("irq on", 8'h01, {7'h00, irq});
    wr(IDX_TCTRL, 8'h00);
    wr(IDX_IMASK, 8'h00);
    repeat (3) @(posedge clock);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(IDX_ISTAT, 8'h01);
    rc(IDX_ISTAT, 8'h00, 8'hFF, "status clear");
    wr(IDX_CKCTL, 8'h30);
    wr(IDX_T2RLL, 8'hF0);
    wr(IDX_T2RLH, 8'hF0);
    wr(IDX_T2LO, 8'hFE);
    wr(IDX_T2HI, 8'h55);
    wr(IDX_IMASK, 8'h04);
    wr(IDX_T2CTL, 8'h08);
    repeat (10) @(posedge clock);
    rc(IDX_T2HI, 8'h55, 8'hFF, "t2 high idle");
    rc(IDX_T2CTL, 8'h48, 8'hFF, "t2 low flag");
    rc(IDX_ISTAT, 8'h00, 8'hFF, "t2 low quiet");
    rc(IDX_T2LO, 8'hF0, 8'hF0, "t2 low reload");
    wr(IDX_T2CTL, 8'h28);
    repeat (20) @(posedge clock);
    chk("irq t2 low", 8'h01, {7'h00, irq});
    wr(IDX_T2CTL, 8'h0C);
    repeat (190) @(posedge clock);
    rc(IDX_T2CTL, 8'hCC, 8'hFF, "t2 both flags");
    rc(IDX_T2HI, 8'hF0, 8'hF0, "t2 high reload");
    t2_rate(8'h00, 8'h08, 8'hF0, 150, 80);
    t2_rate(8'h00, 8'h09, 8'hFE, 60, 200);
    wr(IDX_TMODE, 8'h33);
    rc(IDX_TMODE, 8'h33, 8'hFF, "mode bits");
    scale_rate(2'd0, DIV_SYS12);
    scale_rate(2'd1, DIV_SYS4);
    scale_rate(2'd2, DIV_SYS48);
    scale_rate(2'd3, DIV_EXT8 * EXT_PERIOD);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
